/* rtl/sysctl_defines.svh */
// Offsets, field positions, reset values and timing counts for the system
// control register bank. Assumes inclusion by bare name from rtl files.
`ifndef SYSCTL_DEFINES_SVH
`define SYSCTL_DEFINES_SVH
`define SC_OFF_ZERO 12'h000
`define SC_OFF_ONE 12'h004
`define SC_OFF_TWO 12'h008
`define SC_OFF_STAT 12'h00C
`define SC_OFF_MASK 12'h010
`define SC_OFF_WAKE 12'h014
`define SC_OFF_PULL 12'h018
`define SC_RST_ZERO 8'h00
`define SC_RST_ONE 8'h8A
`define SC_RST_TWO 8'h01
`define SC_RST_WAKE 8'h00
`define SC_RST_PULL 8'h00
`define SC_MASK_ZERO 8'h7F
`define SC_MASK_ONE 8'hFF
`define SC_MASK_TWO 8'hC1
`define SC_B_CLKSRC 0
`define SC_B_XPWR 1
`define SC_B_DIVEN 2
`define SC_B_PWM0 3
`define SC_B_PWM1 4
`define SC_B_PWMRES 5
`define SC_B_DIVSRC 6
`define SC_B_KEEP 0
`define SC_WDT_OFF 4'hA
`define SC_TB_BASE_LOG2 10
`endif

/* rtl/sysctl_pkg.sv */
// Types shared by the system control register bank files.
// Assumes no other package.
package sysctl_pkg;
    typedef enum logic [1:0]
    {
        EDGE_OFF = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_mode_t;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_SETUP = 2'h1,
        ST_ACCESS = 2'h3
    } apb_state_t;
endpackage

/* rtl/pin_sync.sv */
// Three-stage synchroniser with agreement filter for one external pin.
// Assumes clk_sys and rst_n of the register bank.
`timescale 1ns/100ps
module pin_sync
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic pin,
    output logic level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // The filtered level only moves when stages two and three agree.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            level <= 1'b1;
        end
        else
        begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                level <= s3_q;
        end
    end
endmodule

/* rtl/edge_detect.sv */
// Edge detector on a synchronised level, selectable rising/falling/both.
// Assumes the input is already in the clk_sys domain.
`timescale 1ns/100ps
module edge_detect
import sysctl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic level,
    input sysctl_pkg::edge_mode_t mode,
    output logic hit
);
    logic prev_q;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            prev_q <= 1'b1;
        else
            prev_q <= level;
    end

    always_comb
    begin
        case (mode)
            EDGE_RISE: hit = level & ~prev_q;
            EDGE_FALL: hit = ~level & prev_q;
            EDGE_BOTH: hit = level ^ prev_q;
            default: hit = 1'b0;
        endcase
    end
endmodule

/* rtl/sysctl_regs.sv */
// System control register bank with APB slave, pin routing and events.
// Assumes a 10 MHz clk_sys, active-low async rst_n and an APB master.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
`include "sysctl_defines.svh"

////////////////////////////////////////////////////////////////////////////
// What this block does
// - PWM two enable routes its pin to PWM two when 1, else I/O.
// - Divider enable drives its pin from the divider when 1, else I/O.
// - Crystal power bit gives quick start at 0 and low power at 1.
// - Clock bit picks fast RC at 0, slow crystal at 1 with RC stopped.
// - On small variants the clock bit acts only with the RC+crystal option.
// - An enabled PWM output makes the timer/PWM clock the system clock.
// - The timer/PWM clock drives both timers, the time base and PWM.
// - Edge field: 00 off, 01 rising, 10 falling, 11 both edges.
// - Time base field gives 2^10 to 2^13 timer/PWM clock periods.
// - Watchdog code 1010 disables, any other enables; 0101 advised.
// - Watchdog stops only if its option is off and the code is 1010.
// - Pin group field maps divider, timer inputs and irq on four groups.
// - Keep-alive bit keeps the slow crystal running in halt when 1.
// - Bits 5 to 1 of the third register read as zero.
// - An enabled wake pin wakes the device on a falling edge.
// - A pull-up connects only while its pin is an input.
module sysctl_regs
import sysctl_pkg::*;
#(
    parameter int PINS = 8,
    parameter bit SMALL_VARIANT = 1'b0
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic opt_rc_plus_crystal,
    input wire logic opt_watchdog_on,
    input wire logic halted,
    input wire logic pwm0_wave,
    input wire logic pwm1_wave,
    input wire logic programmable_divider_output,
    input wire logic timer_pwm_alt_clock_en,
    input wire logic ext_irq_pin,
    input wire logic [PINS-1:0] wake_pins,
    input wire logic [PINS-1:0] pin_is_input,
    output logic second_pwm_pin_enable,
    output logic pwm1_pin_out,
    output logic first_pwm_pin_enable,
    output logic pwm0_pin_out,
    output logic divider_output_pin_enable,
    output logic divider_pin_out,
    output logic divider_output_source_select,
    output logic pwm_resolution_mode,
    output logic slow_crystal_power_mode,
    output logic system_clock_source_select,
    output logic fast_rc_run,
    output logic slow_crystal_run,
    output logic timer_pwm_from_system,
    output logic [1:0] timebase_period_log2_off,
    output logic [13:0] timebase_period_cycles,
    output logic watchdog_run,
    output logic [1:0] pin_group_select,
    output logic [3:0] pin_group_onehot,
    output logic [PINS-1:0] pullup_on,
    output logic ext_irq_event,
    output logic wake_event,
    output logic irq
);
    if (PINS < 1 || PINS > 8)
    begin : g_pins_check
        $error("PINS must lie between 1 and 8");
    end

    logic [7:0] zero_q;
    logic [7:0] one_q;
    logic [7:0] two_q;
    logic [7:0] wake_sel_q;
    logic [7:0] pull_sel_q;
    logic [1:0] stat_q;
    logic [1:0] mask_q;
    logic [31:0] rdata_d;
    logic decode_ok;
    logic wr_en;
    logic rd_en;
    logic irq_level;
    logic [PINS-1:0] wake_lvl;
    logic [PINS-1:0] wake_hit;
    logic [1:0] stat_set;
    apb_state_t state_q;

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero-wait answer; unmapped addresses answer with pslverr.
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    always_comb
    begin
        decode_ok = 1'b1;
        rdata_d = 32'h0000_0000;
        case (paddr)
            `SC_OFF_ZERO: rdata_d[7:0] = zero_q;
            `SC_OFF_ONE: rdata_d[7:0] = one_q;
            `SC_OFF_TWO: rdata_d[7:0] = two_q & `SC_MASK_TWO;
            `SC_OFF_STAT: rdata_d[1:0] = stat_q;
            `SC_OFF_MASK: rdata_d[1:0] = mask_q;
            `SC_OFF_WAKE: rdata_d[7:0] = wake_sel_q;
            `SC_OFF_PULL: rdata_d[7:0] = pull_sel_q;
            default: decode_ok = 1'b0;
        endcase
    end

    assign pslverr = psel & penable & ~decode_ok;

    // Read data is a registered copy so it stays stable between accesses.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= 32'h0000_0000;
        else if (psel & ~penable & ~pwrite)
            prdata <= rdata_d;
    end

    // Tracks the bus phase for the a_two_zero read-back check.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= ST_IDLE;
        else if (psel & ~penable)
            state_q <= ST_SETUP;
        else if (psel & penable)
            state_q <= ST_ACCESS;
        else
            state_q <= ST_IDLE;
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zero_q <= `SC_RST_ZERO;
            one_q <= `SC_RST_ONE;
            two_q <= `SC_RST_TWO;
            wake_sel_q <= `SC_RST_WAKE;
            pull_sel_q <= `SC_RST_PULL;
            mask_q <= 2'h0;
        end
        else if (wr_en)
        begin
            case (paddr)
                `SC_OFF_ZERO: zero_q <= pwdata[7:0] & `SC_MASK_ZERO;
                `SC_OFF_ONE: one_q <= pwdata[7:0];
                `SC_OFF_TWO: two_q <= pwdata[7:0] & `SC_MASK_TWO;
                `SC_OFF_MASK: mask_q <= pwdata[1:0];
                `SC_OFF_WAKE: wake_sel_q <= pwdata[7:0];
                `SC_OFF_PULL: pull_sel_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin routing and clock control derived from the fields.
    assign second_pwm_pin_enable = zero_q[`SC_B_PWM1];
    assign first_pwm_pin_enable = zero_q[`SC_B_PWM0];
    assign divider_output_pin_enable = zero_q[`SC_B_DIVEN];
    assign divider_output_source_select = zero_q[`SC_B_DIVSRC];
    assign pwm_resolution_mode = zero_q[`SC_B_PWMRES];
    assign slow_crystal_power_mode = zero_q[`SC_B_XPWR];
    assign pwm1_pin_out = second_pwm_pin_enable & pwm1_wave;
    assign pwm0_pin_out = first_pwm_pin_enable & pwm0_wave;
    assign divider_pin_out = divider_output_pin_enable
        & programmable_divider_output;

    // Smaller variants ignore the clock bit without the combined option.
    assign system_clock_source_select = zero_q[`SC_B_CLKSRC]
        & (~SMALL_VARIANT | opt_rc_plus_crystal);
    assign fast_rc_run = ~system_clock_source_select;
    assign slow_crystal_run = system_clock_source_select
        | ~halted | two_q[`SC_B_KEEP];

    // An enabled PWM pin forces the shared timer clock onto the system clock.
    assign timer_pwm_from_system = first_pwm_pin_enable
        | second_pwm_pin_enable | ~timer_pwm_alt_clock_en;

    assign timebase_period_log2_off = one_q[5:4];
    assign timebase_period_cycles = 14'h0001
        << (`SC_TB_BASE_LOG2 + one_q[5:4]);

    assign watchdog_run = opt_watchdog_on
        | (one_q[3:0] != `SC_WDT_OFF);

    assign pin_group_select = two_q[7:6];
    assign pin_group_onehot = 4'h1 << two_q[7:6];

    assign pullup_on = pull_sel_q[PINS-1:0] & pin_is_input;

    ////////////////////////////////////////////////////////////////////////
    // External interrupt and wake events.
    logic irq_lvl;

    pin_sync u_irq_sync
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin(ext_irq_pin),
        .level(irq_lvl)
    );

    edge_detect u_irq_edge
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .level(irq_lvl),
        .mode(edge_mode_t'(one_q[7:6])),
        .hit(ext_irq_event)
    );

    genvar g;
    generate
        for (g = 0; g < PINS; g++)
        begin : g_wake
            pin_sync u_sync
            (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .pin(wake_pins[g]),
                .level(wake_lvl[g])
            );
            edge_detect u_edge
            (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .level(wake_lvl[g]),
                .mode(wake_sel_q[g] ? EDGE_FALL : EDGE_OFF),
                .hit(wake_hit[g])
            );
        end
    endgenerate

    assign wake_event = |wake_hit;
    assign stat_set = {wake_event, ext_irq_event};

    // A new event in the clearing cycle keeps its bit set.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            stat_q <= 2'h0;
        else if (wr_en && paddr == `SC_OFF_STAT)
            stat_q <= (stat_q & ~pwdata[1:0]) | stat_set;
        else
            stat_q <= stat_q | stat_set;
    end

    assign irq_level = |(stat_q & mask_q);
    assign irq = irq_level;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_wdt_off;
        @(posedge clk_sys) disable iff (!rst_n)
        (!opt_watchdog_on && one_q[3:0] == `SC_WDT_OFF) |-> !watchdog_run;
    endproperty
    a_wdt_off: assert property (p_wdt_off)
        else $error("watchdog runs with disable code");

    property p_wdt_on;
        @(posedge clk_sys) disable iff (!rst_n)
        (one_q[3:0] != `SC_WDT_OFF) |-> watchdog_run;
    endproperty
    a_wdt_on: assert property (p_wdt_on)
        else $error("watchdog stopped with enable code");

    property p_two_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_SETUP && paddr == `SC_OFF_TWO && !pwrite)
        |=> prdata[5:1] == 5'h00;
    endproperty
    a_two_zero: assert property (p_two_zero)
        else $error("unimplemented bits read nonzero");

    property p_tb;
        @(posedge clk_sys) disable iff (!rst_n)
        (timebase_period_cycles >> one_q[5:4]) ==
        (14'h0001 << `SC_TB_BASE_LOG2) &&
        $countones(timebase_period_cycles) == 1;
    endproperty
    a_tb: assert property (p_tb)
        else $error("time base period wrong");

    property p_pwm1;
        @(posedge clk_sys) disable iff (!rst_n)
        !second_pwm_pin_enable |-> !pwm1_pin_out;
    endproperty
    a_pwm1: assert property (p_pwm1)
        else $error("pwm pin driven while in io mode");

    property p_div;
        @(posedge clk_sys) disable iff (!rst_n)
        divider_output_pin_enable |->
        divider_pin_out == programmable_divider_output;
    endproperty
    a_div: assert property (p_div)
        else $error("divider pin not following divider");

    property p_clk;
        @(posedge clk_sys) disable iff (!rst_n)
        system_clock_source_select |-> !fast_rc_run;
    endproperty
    a_clk: assert property (p_clk)
        else $error("fast rc running on slow clock");

    property p_small;
        @(posedge clk_sys) disable iff (!rst_n)
        (SMALL_VARIANT && !opt_rc_plus_crystal) |->
        !system_clock_source_select;
    endproperty
    a_small: assert property (p_small)
        else $error("clock bit acts without option");

    property p_pwmclk;
        @(posedge clk_sys) disable iff (!rst_n)
        (first_pwm_pin_enable || second_pwm_pin_enable)
        |-> timer_pwm_from_system;
    endproperty
    a_pwmclk: assert property (p_pwmclk)
        else $error("pwm enabled without system clock");

    property p_keep;
        @(posedge clk_sys) disable iff (!rst_n)
        (halted && two_q[0]) |-> slow_crystal_run;
    endproperty
    a_keep: assert property (p_keep)
        else $error("crystal stopped with keep alive");

    property p_pull;
        @(posedge clk_sys) disable iff (!rst_n)
        (pullup_on & ~pin_is_input) == '0;
    endproperty
    a_pull: assert property (p_pull)
        else $error("pull up on output pin");

    property p_sticky;
        @(posedge clk_sys) disable iff (!rst_n)
        ext_irq_event |=> stat_q[0];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("irq event lost");

    c_irq: cover property (@(posedge clk_sys) disable iff (!rst_n) irq);
    c_wake: cover property (@(posedge clk_sys) disable iff (!rst_n)
        wake_event);
    c_wdt: cover property (@(posedge clk_sys) disable iff (!rst_n)
        !watchdog_run);
    c_err: cover property (@(posedge clk_sys) disable iff (!rst_n)
        pslverr);
endmodule

/* bench/sysctl_regs_bench.sv */
// Self-checking bench for the system control register bank.
// Assumes the rtl files and the defines header are on the compile path.
`timescale 1ns/100ps
`include "sysctl_defines.svh"
module sysctl_regs_bench;

////////////////////////////////////////////////////////////////////////////
logic clk_sys = 1'b0;
logic rst_n = 1'b0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0000_0000;
logic [31:0] prdata;
logic pready;
logic pslverr;
logic opt_rc_plus_crystal = 1'b1;
logic opt_watchdog_on = 1'b0;
logic halted = 1'b0;
logic pwm0_wave = 1'b1;
logic pwm1_wave = 1'b1;
logic programmable_divider_output = 1'b1;
logic timer_pwm_alt_clock_en = 1'b1;
logic ext_irq_pin = 1'b1;
logic [7:0] wake_pins = 8'hFF;
logic [7:0] pin_is_input = 8'h0F;
logic second_pwm_pin_enable, pwm1_pin_out, first_pwm_pin_enable;
logic pwm0_pin_out, divider_output_pin_enable, divider_pin_out;
logic divider_output_source_select, pwm_resolution_mode;
logic slow_crystal_power_mode, system_clock_source_select, fast_rc_run;
logic slow_crystal_run, timer_pwm_from_system, watchdog_run;
logic [1:0] timebase_period_log2_off, pin_group_select;
logic [13:0] timebase_period_cycles;
logic [3:0] pin_group_onehot;
logic [7:0] pullup_on;
logic ext_irq_event, wake_event, irq;
logic small_clk_sel;
int failures = 0;
int compares = 0;

always #50 clk_sys = ~clk_sys;

sysctl_regs #(.PINS(8), .SMALL_VARIANT(1'b0)) sysctl_regs_inst
(
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .opt_rc_plus_crystal(opt_rc_plus_crystal),
    .opt_watchdog_on(opt_watchdog_on), .halted(halted),
    .pwm0_wave(pwm0_wave), .pwm1_wave(pwm1_wave),
    .programmable_divider_output(programmable_divider_output),
    .timer_pwm_alt_clock_en(timer_pwm_alt_clock_en),
    .ext_irq_pin(ext_irq_pin), .wake_pins(wake_pins),
    .pin_is_input(pin_is_input),
    .second_pwm_pin_enable(second_pwm_pin_enable),
    .pwm1_pin_out(pwm1_pin_out),
    .first_pwm_pin_enable(first_pwm_pin_enable),
    .pwm0_pin_out(pwm0_pin_out),
    .divider_output_pin_enable(divider_output_pin_enable),
    .divider_pin_out(divider_pin_out),
    .divider_output_source_select(divider_output_source_select),
    .pwm_resolution_mode(pwm_resolution_mode),
    .slow_crystal_power_mode(slow_crystal_power_mode),
    .system_clock_source_select(system_clock_source_select),
    .fast_rc_run(fast_rc_run), .slow_crystal_run(slow_crystal_run),
    .timer_pwm_from_system(timer_pwm_from_system),
    .timebase_period_log2_off(timebase_period_log2_off),
    .timebase_period_cycles(timebase_period_cycles),
    .watchdog_run(watchdog_run), .pin_group_select(pin_group_select),
    .pin_group_onehot(pin_group_onehot), .pullup_on(pullup_on),
    .ext_irq_event(ext_irq_event), .wake_event(wake_event), .irq(irq)
);

// Small variant: only its clock select is watched, the rest is left open.
sysctl_regs #(.PINS(8), .SMALL_VARIANT(1'b1)) small_sysctl_regs_inst
(
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .opt_rc_plus_crystal(opt_rc_plus_crystal),
    .opt_watchdog_on(opt_watchdog_on), .halted(halted),
    .pwm0_wave(pwm0_wave), .pwm1_wave(pwm1_wave),
    .programmable_divider_output(programmable_divider_output),
    .timer_pwm_alt_clock_en(timer_pwm_alt_clock_en),
    .ext_irq_pin(ext_irq_pin), .wake_pins(wake_pins),
    .pin_is_input(pin_is_input), .second_pwm_pin_enable(),
    .pwm1_pin_out(), .first_pwm_pin_enable(), .pwm0_pin_out(),
    .divider_output_pin_enable(), .divider_pin_out(),
    .divider_output_source_select(), .pwm_resolution_mode(),
    .slow_crystal_power_mode(),
    .system_clock_source_select(small_clk_sel), .fast_rc_run(),
    .slow_crystal_run(), .timer_pwm_from_system(),
    .timebase_period_log2_off(), .timebase_period_cycles(),
    .watchdog_run(), .pin_group_select(), .pin_group_onehot(),
    .pullup_on(), .ext_irq_event(), .wake_event(), .irq()
);

////////////////////////////////////////////////////////////////////////////
task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
    begin
        $display("SIMULATION PASSED");
    end
    else
    begin
        $display("SIMULATION FAILED");
    end
    $finish;
endtask

task automatic chk(input string what, input logic [31:0] exp,
                   input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
        failures++;
        $display("mismatch %s expected %h seen %h", what, exp, got);
    end
endtask

// Every transfer starts right after an edge and ends one edge after the
// release, so no strobe is driven twice in one time step.
task automatic apb(input logic wr, input logic [11:0] a,
                   input logic [31:0] d, output logic [31:0] rd,
                   output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
        @(posedge clk_sys);
        n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
        failures++;
        $display("mismatch pready expected 1 seen timeout");
        tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
endtask

task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, {24'h000000, d}, rd, err);
    chk("pslverr", 32'h0000_0000, {31'h0, err});
endtask

task automatic rdc(input string what, input logic [11:0] a,
                   input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(what, exp, rd);
endtask

// Events are one-cycle pulses; sample them once per cycle, settled.
task automatic pulses(input bit wake, output int cnt);
    cnt = 0;
    repeat (12)
    begin
        @(posedge clk_sys);
        #1;
        if ((wake ? wake_event : ext_irq_event) === 1'b1)
            cnt++;
    end
    @(posedge clk_sys);
endtask

////////////////////////////////////////////////////////////////////////////
initial
begin
    int c;
    logic [31:0] rd;
    logic err;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk("wdt_reset", 32'h0, {31'h0, watchdog_run});
    rdc("zero_rst", `SC_OFF_ZERO, {24'h0, `SC_RST_ZERO});
    rdc("one_rst", `SC_OFF_ONE, {24'h0, `SC_RST_ONE});
    rdc("two_rst", `SC_OFF_TWO, {24'h0, `SC_RST_TWO});
    rdc("stat_rst", `SC_OFF_STAT, 32'h0);
    rdc("mask_rst", `SC_OFF_MASK, 32'h0);
    wr(`SC_OFF_ZERO, 8'hFF);
    rdc("zero_rb", `SC_OFF_ZERO, 32'h7F);
    chk("zero_outs", 32'hFFB, 32'({pwm_resolution_mode,
        divider_output_source_select, pwm0_pin_out, second_pwm_pin_enable,
        pwm1_pin_out, divider_output_pin_enable, divider_pin_out,
        slow_crystal_power_mode, system_clock_source_select, fast_rc_run,
        timer_pwm_from_system,
        first_pwm_pin_enable}));
    chk("small_opt", 32'h1, {31'h0, small_clk_sel});
    opt_rc_plus_crystal <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("small_noopt", 32'h2, {30'h0, system_clock_source_select,
        small_clk_sel});
    @(posedge clk_sys);
    opt_rc_plus_crystal <= 1'b1;
    wr(`SC_OFF_ZERO, 8'h00);
    chk("zero_outs", 32'h004, 32'({pwm_resolution_mode,
        divider_output_source_select, pwm0_pin_out, second_pwm_pin_enable,
        pwm1_pin_out, divider_output_pin_enable, divider_pin_out,
        slow_crystal_power_mode, system_clock_source_select, fast_rc_run,
        timer_pwm_from_system,
        first_pwm_pin_enable}));
    apb(1'b1, `SC_OFF_ZERO, 32'hFFFF_FF12, rd, err);
    rdc("zero_wide", `SC_OFF_ZERO, 32'h12);
    for (int k = 0; k < 4; k++)
    begin
        wr(`SC_OFF_ONE, {2'b00, 2'(k), 4'h5});
        chk("tb_cycles", 32'(14'h0400 << k),
            {18'h0, timebase_period_cycles});
        chk("tb_sel", 32'(k), {30'h0, timebase_period_log2_off});
        chk("wdt_on", 32'h1, {31'h0, watchdog_run});
        wr(`SC_OFF_TWO, {2'(k), 6'h01});
        chk("grp", 32'(4'h1 << k), {28'h0, pin_group_onehot});
        chk("grp_sel", 32'(k), {30'h0, pin_group_select});
    end
    wr(`SC_OFF_ONE, 8'h0A);
    chk("wdt_off", 32'h0, {31'h0, watchdog_run});
    opt_watchdog_on <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("wdt_opt", 32'h1, {31'h0, watchdog_run});
    @(posedge clk_sys);
    opt_watchdog_on <= 1'b0;
    wr(`SC_OFF_TWO, 8'hFF);
    rdc("two_rb", `SC_OFF_TWO, 32'hC1);
    halted <= 1'b1;
    @(posedge clk_sys);
    chk("keep_on", 32'h1, {31'h0, slow_crystal_run});
    wr(`SC_OFF_TWO, 8'h00);
    chk("keep_off", 32'h0, {31'h0, slow_crystal_run});
    halted <= 1'b0;
    wr(`SC_OFF_PULL, 8'h33);
    chk("pullup", 32'h03, {24'h0, pullup_on});
    for (int m = 0; m < 4; m++)
    begin
        wr(`SC_OFF_ONE, {2'(m), 6'h05});
        ext_irq_pin <= 1'b0;
        pulses(1'b0, c);
        chk("fall_evt", 32'(m >> 1), 32'(c));
        ext_irq_pin <= 1'b1;
        pulses(1'b0, c);
        chk("rise_evt", 32'(m & 1), 32'(c));
    end
    rdc("stat_irq", `SC_OFF_STAT, 32'h1);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(`SC_OFF_MASK, 8'h01);
    chk("irq_up", 32'h1, {31'h0, irq});
    wr(`SC_OFF_STAT, 8'h01);
    rdc("stat_clr", `SC_OFF_STAT, 32'h0);
    chk("irq_clr", 32'h0, {31'h0, irq});
    wr(`SC_OFF_MASK, 8'h00);
    wr(`SC_OFF_WAKE, 8'h01);
    wake_pins <= 8'hFE;
    pulses(1'b1, c);
    chk("wake_sel", 32'h1, 32'(c));
    wake_pins <= 8'hFC;
    pulses(1'b1, c);
    chk("wake_unsel", 32'h0, 32'(c));
    wake_pins <= 8'hFF;
    rdc("stat_wake", `SC_OFF_STAT, 32'h2);
    wr(`SC_OFF_STAT, 8'h02);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rdc("one_rst2", `SC_OFF_ONE, {24'h0, `SC_RST_ONE});
    rdc("zero_rst2", `SC_OFF_ZERO, {24'h0, `SC_RST_ZERO});
    apb(1'b1, 12'h01C, 32'h0000_00FF, rd, err);
    chk("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b0, 12'h01C, 32'h0000_0000, rd, err);
    chk("unmapped_rd", 32'h0, rd);
    tally_and_finish();
end

endmodule
